// file: rtl/fse_pkg.sv
// fse_pkg: constants and carrier types of the flash status and error logic.
// assumes one system clock; command codes sit in the low byte of a bus write.
package fse_pkg;

	// ----------------------------------------------------------------
	// command codes, low byte of the written word
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
	localparam logic [7:0] CMD_ERASE_ALL = 8'hA7;
	localparam logic [7:0] CMD_LOCK_PROGRAM = 8'h77;
	localparam logic [7:0] CMD_READ_LOCK = 8'h71;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;

	// ----------------------------------------------------------------
	// status byte layout and reset values
	// ----------------------------------------------------------------
	localparam int STAT_READY_POS = 7;
	localparam int STAT_ERASE_POS = 5;
	localparam int STAT_PROG_POS = 4;
	localparam logic RST_READY = 1'b1;
	localparam logic RST_ERASE_FAIL = 1'b0;
	localparam logic RST_PROG_FAIL = 1'b0;
	localparam logic [7:0] RST_STATUS = 8'h80;

	// ----------------------------------------------------------------
	// bus and core carriers
	// ----------------------------------------------------------------
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} fse_bus_req_t;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_PROGRAM,
		OP_BLOCK_ERASE,
		OP_ERASE_ALL,
		OP_LOCK_PROGRAM,
		OP_READ_LOCK
	} fse_op_t;

	typedef struct packed {
		logic start;
		fse_op_t op;
		logic lock_bypass;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fse_core_cmd_t;

endpackage : fse_pkg

// file: rtl/fse_status_logic.sv
// fse_status_logic: command sequencer status byte and error flags.
// assumes bus strobes and flash core answers are on sys_clk already;
// the core pulses core_done once per started operation.
`timescale 1ns/1ps

// Behaviour
// - in rewrite mode 0, after the read status command, even user ROM reads return the status byte.
// - in rewrite mode 0, starting program, erase, erase-all or lock program keeps status reads on until read array.
// - the ready bit is 0 while program, erase, erase-all, lock program or lock read runs, else 1.
// - the status byte holds ready in D7, erase result in D5, program result in D4, mirrored by the control flags.
// - result bits mean 0 normal and 1 error; after reset both are 0 and ready is 1.
// - while status reads are on, all eight status bits go out on data lines D0 to D7.
// - the clear status command resets both result bits in the byte and the mirror.
// - while either result bit is 1, program, erase, erase-all and lock program commands are refused.
// - a second cycle code other than D0 or FF after lock program, erase or erase-all sets both result bits.
// - erasing a locked block or a failed erase reports erase bit 1 and program bit 0.
// - programming a locked block, a failed program or failed lock program reports erase 0 and program 1.
// - code FF in that second cycle discards the first command and returns to read array.
// - with lock protection disabled none of these errors is raised.
// - lock protection disabled makes every block act unlocked while stored lock bits stay.
module fse_status_logic #(
	parameter logic [fse_pkg::ADDR_W-1:0] ROM_BASE = 20'h80000,
	parameter logic [fse_pkg::ADDR_W-1:0] ROM_LAST = 20'hFFFFF
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic cpu_rewrite_mode_0,
	input wire logic lock_protect_disable,
	input wire fse_pkg::fse_bus_req_t bus_req,
	input wire logic target_locked,
	input wire logic core_done,
	input wire logic core_fail,
	output fse_pkg::fse_core_cmd_t core_cmd,
	output logic [7:0] rd_data,
	output logic rd_status_sel,
	output logic ctrl_ready_flag,
	output logic ctrl_erase_fail_flag,
	output logic ctrl_program_fail_flag
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SECOND,
		ST_BUSY
	} fse_seq_t;

	fse_seq_t seq_q, seq_d;
	fse_pkg::fse_op_t pend_q, pend_d;
	fse_pkg::fse_core_cmd_t cmd_q, cmd_d;
	logic status_mode_q, status_mode_d;
	logic ready_q, ready_d;
	logic erase_fail_q, erase_fail_d;
	logic prog_fail_q, prog_fail_d;
	logic [7:0] rd_data_q, rd_data_d;
	logic rd_sel_q, rd_sel_d;

	logic [7:0] code;
	logic any_fail;
	logic eff_locked;
	logic rom_even;
	logic [7:0] status_byte;

	assign code = bus_req.wdata[7:0];
	assign any_fail = erase_fail_q | prog_fail_q;
	// stored lock bit is ignored, not altered, when protection is off
	assign eff_locked = target_locked & ~lock_protect_disable;
	assign rom_even = ~bus_req.addr[0] && (bus_req.addr >= ROM_BASE)
		&& (bus_req.addr <= ROM_LAST);

	always_comb begin
		status_byte = 8'h00;
		status_byte[fse_pkg::STAT_READY_POS] = ready_q;
		status_byte[fse_pkg::STAT_ERASE_POS] = erase_fail_q;
		status_byte[fse_pkg::STAT_PROG_POS] = prog_fail_q;
	end

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	always_comb begin
		seq_d = seq_q;
		pend_d = pend_q;
		cmd_d = cmd_q;
		cmd_d.start = 1'b0;
		status_mode_d = status_mode_q;
		erase_fail_d = erase_fail_q;
		prog_fail_d = prog_fail_q;
		case (seq_q)
			ST_IDLE: begin
				if (bus_req.wr) begin
					if (code == fse_pkg::CMD_READ_ARRAY) begin
						status_mode_d = 1'b0;
					end else if (code == fse_pkg::CMD_READ_STATUS) begin
						status_mode_d = 1'b1;
					end else if (code == fse_pkg::CMD_CLEAR_STATUS) begin
						erase_fail_d = 1'b0;
						prog_fail_d = 1'b0;
					end else if (code == fse_pkg::CMD_READ_LOCK) begin
						pend_d = fse_pkg::OP_READ_LOCK;
						seq_d = ST_SECOND;
					end else if (!any_fail) begin
						// refused codes leave no trace; software sees the flags
						if (code == fse_pkg::CMD_PROGRAM) begin
							pend_d = fse_pkg::OP_PROGRAM;
							seq_d = ST_SECOND;
						end else if (code == fse_pkg::CMD_BLOCK_ERASE) begin
							pend_d = fse_pkg::OP_BLOCK_ERASE;
							seq_d = ST_SECOND;
						end else if (code == fse_pkg::CMD_ERASE_ALL) begin
							pend_d = fse_pkg::OP_ERASE_ALL;
							seq_d = ST_SECOND;
						end else if (code == fse_pkg::CMD_LOCK_PROGRAM) begin
							pend_d = fse_pkg::OP_LOCK_PROGRAM;
							seq_d = ST_SECOND;
						end
					end
				end
			end
			ST_SECOND: begin
				if (bus_req.wr) begin
					seq_d = ST_IDLE;
					pend_d = fse_pkg::OP_NONE;
					cmd_d.op = pend_q;
					cmd_d.addr = bus_req.addr;
					cmd_d.data = bus_req.wdata;
					cmd_d.lock_bypass = lock_protect_disable;
					if (pend_q == fse_pkg::OP_PROGRAM) begin
						if (eff_locked) begin
							prog_fail_d = 1'b1;
							status_mode_d = cpu_rewrite_mode_0;
						end else begin
							cmd_d.start = 1'b1;
							seq_d = ST_BUSY;
							if (cpu_rewrite_mode_0) begin
								status_mode_d = 1'b1;
							end
						end
					end else if (code == fse_pkg::CMD_READ_ARRAY) begin
						status_mode_d = 1'b0;
					end else if (code == fse_pkg::CMD_CONFIRM) begin
						if (pend_q == fse_pkg::OP_BLOCK_ERASE && eff_locked) begin
							erase_fail_d = 1'b1;
							status_mode_d = cpu_rewrite_mode_0;
						end else begin
							cmd_d.start = 1'b1;
							seq_d = ST_BUSY;
							if (cpu_rewrite_mode_0 &&
								pend_q != fse_pkg::OP_READ_LOCK) begin
								status_mode_d = 1'b1;
							end
						end
					end else if (pend_q != fse_pkg::OP_READ_LOCK &&
						!lock_protect_disable) begin
						erase_fail_d = 1'b1;
						prog_fail_d = 1'b1;
						status_mode_d = cpu_rewrite_mode_0;
					end
				end
			end
			ST_BUSY: begin
				// writes during an operation are dropped
				if (core_done) begin
					seq_d = ST_IDLE;
					if (core_fail && !lock_protect_disable) begin
						if (cmd_q.op == fse_pkg::OP_BLOCK_ERASE ||
							cmd_q.op == fse_pkg::OP_ERASE_ALL) begin
							erase_fail_d = 1'b1;
						end else if (cmd_q.op == fse_pkg::OP_PROGRAM ||
							cmd_q.op == fse_pkg::OP_LOCK_PROGRAM) begin
							prog_fail_d = 1'b1;
						end
					end
				end
			end
			default: begin
				seq_d = ST_IDLE;
			end
		endcase
		ready_d = (seq_d != ST_BUSY);
	end

	// ----------------------------------------------------------------
	// status read port
	// ----------------------------------------------------------------
	always_comb begin
		rd_data_d = 8'h00;
		rd_sel_d = 1'b0;
		if (bus_req.rd && rom_even && cpu_rewrite_mode_0 &&
			status_mode_q) begin
			rd_data_d = status_byte;
			rd_sel_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			seq_q <= ST_IDLE;
			pend_q <= fse_pkg::OP_NONE;
			cmd_q <= '0;
			status_mode_q <= 1'b0;
			ready_q <= fse_pkg::RST_READY;
			erase_fail_q <= fse_pkg::RST_ERASE_FAIL;
			prog_fail_q <= fse_pkg::RST_PROG_FAIL;
			rd_data_q <= 8'h00;
			rd_sel_q <= 1'b0;
		end else if (clk_en) begin
			seq_q <= seq_d;
			pend_q <= pend_d;
			cmd_q <= cmd_d;
			status_mode_q <= status_mode_d;
			ready_q <= ready_d;
			erase_fail_q <= erase_fail_d;
			prog_fail_q <= prog_fail_d;
			rd_data_q <= rd_data_d;
			rd_sel_q <= rd_sel_d;
		end
	end

	assign core_cmd = cmd_q;
	assign rd_data = rd_data_q;
	assign rd_status_sel = rd_sel_q;
	assign ctrl_ready_flag = ready_q;
	assign ctrl_erase_fail_flag = erase_fail_q;
	assign ctrl_program_fail_flag = prog_fail_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking fse_cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic wr_now;
	logic gated_op;
	assign wr_now = clk_en && bus_req.wr;
	assign gated_op = code == fse_pkg::CMD_PROGRAM ||
		code == fse_pkg::CMD_BLOCK_ERASE ||
		code == fse_pkg::CMD_ERASE_ALL ||
		code == fse_pkg::CMD_LOCK_PROGRAM;

	AST_RESET_VALUES: assert property (disable iff (1'b0) rst |=>
		ctrl_ready_flag && !ctrl_erase_fail_flag && !ctrl_program_fail_flag)
		else $error("status flags wrong after reset");
	AST_READY_BUSY: assert property (
		(seq_q == ST_BUSY) == !ctrl_ready_flag)
		else $error("ready flag disagrees with busy state");
	AST_RESERVED_ZERO: assert property (rd_status_sel |->
		rd_data[6] == 1'b0 && rd_data[3:0] == 4'h0)
		else $error("reserved status bits not zero");
	AST_BYTE_MIRROR: assert property (clk_en && bus_req.rd && rom_even &&
		cpu_rewrite_mode_0 && status_mode_q |=> rd_status_sel &&
		rd_data[7] == $past(ready_q) && rd_data[5] == $past(erase_fail_q) &&
		rd_data[4] == $past(prog_fail_q))
		else $error("status byte does not mirror flags");
	AST_CLEAR: assert property (wr_now && seq_q == ST_IDLE &&
		code == fse_pkg::CMD_CLEAR_STATUS |=> !erase_fail_q && !prog_fail_q)
		else $error("clear status left a result bit set");
	AST_REFUSE: assert property (wr_now && seq_q == ST_IDLE && any_fail &&
		gated_op |=> seq_q == ST_IDLE ##1 !core_cmd.start)
		else $error("command accepted while an error flag is set");
	AST_SEQ_ERROR: assert property (wr_now && seq_q == ST_SECOND &&
		pend_q != fse_pkg::OP_PROGRAM && pend_q != fse_pkg::OP_READ_LOCK &&
		code != fse_pkg::CMD_CONFIRM && code != fse_pkg::CMD_READ_ARRAY &&
		!lock_protect_disable |=> erase_fail_q && prog_fail_q)
		else $error("sequence error not flagged");
	AST_ABORT_FF: assert property (wr_now && seq_q == ST_SECOND &&
		pend_q != fse_pkg::OP_PROGRAM && code == fse_pkg::CMD_READ_ARRAY |=>
		seq_q == ST_IDLE && !status_mode_q && !core_cmd.start)
		else $error("read array abort did not discard command");
	AST_ERASE_FAIL: assert property (clk_en && seq_q == ST_BUSY &&
		core_done && core_fail && !lock_protect_disable &&
		cmd_q.op == fse_pkg::OP_BLOCK_ERASE |=> erase_fail_q && !prog_fail_q)
		else $error("erase failure not reported");
	AST_PROG_FAIL: assert property (clk_en && seq_q == ST_BUSY &&
		core_done && core_fail && !lock_protect_disable &&
		cmd_q.op == fse_pkg::OP_PROGRAM |=> prog_fail_q && !erase_fail_q)
		else $error("program failure not reported");
	AST_NO_ERR_BYPASS: assert property (lock_protect_disable &&
		!erase_fail_q && !prog_fail_q |=> !erase_fail_q && !prog_fail_q)
		else $error("error raised with protection disabled");
	AST_START_STATUS: assert property (clk_en && cmd_d.start &&
		cpu_rewrite_mode_0 && pend_q != fse_pkg::OP_READ_LOCK |=>
		status_mode_q ##1 !ctrl_ready_flag)
		else $error("status reads not on after start");
	AST_READY_RETURN: assert property (clk_en && seq_q == ST_BUSY &&
		core_done |=> ctrl_ready_flag)
		else $error("ready did not return after the operation");
	AST_LOCK_BYPASS: assert property (wr_now && seq_q == ST_SECOND &&
		pend_q == fse_pkg::OP_BLOCK_ERASE && code == fse_pkg::CMD_CONFIRM &&
		lock_protect_disable |=> core_cmd.start && core_cmd.lock_bypass)
		else $error("locked block not erased with protection off");

	COV_PROGRAM_OK: cover property (seq_q == ST_BUSY && core_done &&
		!core_fail && cmd_q.op == fse_pkg::OP_PROGRAM);
	COV_ERASE_LOCKED: cover property (wr_now && seq_q == ST_SECOND &&
		pend_q == fse_pkg::OP_BLOCK_ERASE && eff_locked);
	COV_SEQ_ERROR: cover property (erase_fail_q && prog_fail_q);
	COV_STATUS_READ: cover property (rd_status_sel && !rd_data[7]);

endmodule : fse_status_logic

// file: sim/fse_core_model.sv
// fse_core_model: behavioural flash core that answers started operations.
// assumes start is a one-cycle pulse on sys_clk; delay and outcome from tb.
`timescale 1ns/1ps
module fse_core_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] delay,
	input wire logic fail_in,
	output logic done,
	output logic fail
);
	// ----------------------------------------------------------------
	// countdown to one done pulse per start
	// ----------------------------------------------------------------
	logic [7:0] cnt_q;
	logic junk_q;
	// fail wanders outside done, so the design must qualify it with done
	assign fail = done ? fail_in : junk_q;
	always_ff @(posedge sys_clk) begin
		done <= 1'b0;
		junk_q <= rst ? 1'b0 : ~junk_q;
		if (rst) begin
			cnt_q <= 8'h00;
		end else if (start) begin
			cnt_q <= delay;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
			done <= (cnt_q == 8'h01);
		end
	end
endmodule : fse_core_model

// file: sim/tb.sv
// tb: self-checking bench for the status and error logic.
// assumes fse_pkg and fse_status_logic compiled first; core is modelled.
`timescale 1ns/1ps
module tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cpu_rewrite_mode_0 = 1'b1;
	logic lock_protect_disable = 1'b0;
	fse_pkg::fse_bus_req_t bus_req = '0;
	logic target_locked = 1'b0;
	logic clk_en = 1'b1;
	logic core_done;
	logic core_fail;
	logic fail_cmd = 1'b0;
	logic [7:0] core_delay = 8'h06;
	fse_pkg::fse_core_cmd_t core_cmd;
	logic [7:0] rd_data;
	logic rd_status_sel;
	logic ctrl_ready_flag;
	logic ctrl_erase_fail_flag;
	logic ctrl_program_fail_flag;
	int num_errors = 0;
	int total_checks = 0;
	logic [15:0] dat;
	logic [19:0] ea;
	logic [7:0] bad;
	logic [7:0] cmds [3];

	always #5 sys_clk = ~sys_clk;

	fse_status_logic i_fse_status_logic (.sys_clk(sys_clk), .rst(rst),
		.clk_en(clk_en), .cpu_rewrite_mode_0(cpu_rewrite_mode_0),
		.lock_protect_disable(lock_protect_disable), .bus_req(bus_req),
		.target_locked(target_locked), .core_done(core_done),
		.core_fail(core_fail), .core_cmd(core_cmd), .rd_data(rd_data),
		.rd_status_sel(rd_status_sel), .ctrl_ready_flag(ctrl_ready_flag),
		.ctrl_erase_fail_flag(ctrl_erase_fail_flag),
		.ctrl_program_fail_flag(ctrl_program_fail_flag));
	fse_core_model i_fse_core_model (.sys_clk(sys_clk), .rst(rst),
		.start(core_cmd.start), .delay(core_delay), .fail_in(fail_cmd),
		.done(core_done), .fail(core_fail));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got,
				exp);
		end
	endtask : chk

	function automatic logic [7:0] sbyte(input logic r, input logic e,
		input logic p);
		return {r, 1'b0, e, p, 4'h0};
	endfunction : sbyte

	task automatic flags(input logic r, input logic e, input logic p);
		chk({5'h00, ctrl_ready_flag, ctrl_erase_fail_flag,
			ctrl_program_fail_flag}, {5'h00, r, e, p}, "flags");
	endtask : flags

	task automatic wr(input logic [15:0] d, input logic [19:0] a);
		@(posedge sys_clk);
		bus_req.wr <= 1'b1;
		bus_req.addr <= a;
		bus_req.wdata <= d;
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
		@(negedge sys_clk);
	endtask : wr

	task automatic rd(input logic [19:0] a, input logic sel,
		input logic [7:0] exp);
		@(posedge sys_clk);
		bus_req.rd <= 1'b1;
		bus_req.addr <= a;
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		@(negedge sys_clk);
		chk({7'h00, rd_status_sel}, {7'h00, sel}, "status select");
		chk(rd_data, sel ? exp : 8'h00, "status byte");
	endtask : rd

	task automatic op2(input logic [7:0] c1, input logic [15:0] d2,
		input logic st);
		wr({8'($urandom), c1}, ea);
		wr(d2, ea);
		chk({7'h00, core_cmd.start}, {7'h00, st}, "start pulse");
	endtask : op2

	task automatic wait_ready;
		int n;
		n = 0;
		while (ctrl_ready_flag !== 1'b1 && n < 300) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 300) begin
			num_errors++;
			$display("Error at %0t: ready never returned", $time);
			wrap_up();
		end
	endtask : wait_ready

	task automatic clear;
		wr(16'h0050, ea);
		flags(1'b1, 1'b0, 1'b0);
	endtask : clear

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(95));
		cmds = '{fse_pkg::CMD_BLOCK_ERASE, fse_pkg::CMD_ERASE_ALL,
			fse_pkg::CMD_LOCK_PROGRAM};
		ea = 20'h80000 | (20'($urandom) & 20'h7FFFE);
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		flags(1'b1, 1'b0, 1'b0);
		rd(ea, 1'b0, 8'h00);
		wr(16'h0070, ea);
		rd(ea, 1'b1, sbyte(1'b1, 1'b0, 1'b0));
		rd(ea | 20'h00001, 1'b0, 8'h00);
		rd(20'h7FFFE, 1'b0, 8'h00);
		@(posedge sys_clk);
		fail_cmd <= 1'b1;
		op2(fse_pkg::CMD_BLOCK_ERASE, 16'h00D0, 1'b1);
		chk(8'(core_cmd.op), 8'(fse_pkg::OP_BLOCK_ERASE), "op");
		chk(core_cmd.addr[7:0], ea[7:0], "address");
		flags(1'b0, 1'b0, 1'b0);
		rd(ea, 1'b1, sbyte(1'b0, 1'b0, 1'b0));
		wait_ready();
		flags(1'b1, 1'b1, 1'b0);
		rd(ea, 1'b1, sbyte(1'b1, 1'b1, 1'b0));
		op2(fse_pkg::CMD_ERASE_ALL, 16'h00D0, 1'b0);
		flags(1'b1, 1'b1, 1'b0);
		clear();
		rd(ea, 1'b1, sbyte(1'b1, 1'b0, 1'b0));
		// corrupted second cycles, then the abort code
		foreach (cmds[i]) begin
			do bad = 8'($urandom); while (bad == 8'hD0 || bad == 8'hFF);
			op2(cmds[i], {8'($urandom), bad}, 1'b0);
			flags(1'b1, 1'b1, 1'b1);
			clear();
			op2(cmds[i], {8'($urandom), 8'hFF}, 1'b0);
			flags(1'b1, 1'b0, 1'b0);
			rd(ea, 1'b0, 8'h00);
		end
		// locked targets and core failures
		@(posedge sys_clk);
		target_locked <= 1'b1;
		op2(fse_pkg::CMD_PROGRAM, 16'($urandom), 1'b0);
		flags(1'b1, 1'b0, 1'b1);
		// mid-run reset must drop a pending error and status mode
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		flags(1'b1, 1'b0, 1'b0);
		rd(ea, 1'b0, 8'h00);
		clear();
		op2(fse_pkg::CMD_BLOCK_ERASE, 16'h00D0, 1'b0);
		flags(1'b1, 1'b1, 1'b0);
		// frozen clock enable must swallow the clear
		@(posedge sys_clk);
		clk_en <= 1'b0;
		wr(16'h0050, ea);
		flags(1'b1, 1'b1, 1'b0);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		clear();
		@(posedge sys_clk);
		target_locked <= 1'b0;
		dat = 16'($urandom);
		op2(fse_pkg::CMD_PROGRAM, dat, 1'b1);
		chk(core_cmd.data[7:0], dat[7:0], "program data");
		chk(core_cmd.data[15:8], dat[15:8], "program data high");
		wait_ready();
		flags(1'b1, 1'b0, 1'b1);
		clear();
		op2(fse_pkg::CMD_LOCK_PROGRAM, 16'h00D0, 1'b1);
		wait_ready();
		flags(1'b1, 1'b0, 1'b1);
		clear();
		// protection disabled: locked block erased, no errors
		// core failure and lock are both ignored while protection is off
		@(posedge sys_clk);
		lock_protect_disable <= 1'b1;
		target_locked <= 1'b1;
		op2(fse_pkg::CMD_BLOCK_ERASE, 16'h00D0, 1'b1);
		chk({7'h00, core_cmd.lock_bypass}, 8'h01, "bypass");
		wait_ready();
		flags(1'b1, 1'b0, 1'b0);
		op2(fse_pkg::CMD_BLOCK_ERASE, {8'h00, bad}, 1'b0);
		flags(1'b1, 1'b0, 1'b0);
		@(posedge sys_clk);
		lock_protect_disable <= 1'b0;
		target_locked <= 1'b0;
		fail_cmd <= 1'b0;
		// lock read busy, then a clean program and read array
		op2(fse_pkg::CMD_READ_LOCK, 16'h00D0, 1'b1);
		flags(1'b0, 1'b0, 1'b0);
		wait_ready();
		flags(1'b1, 1'b0, 1'b0);
		wr(16'h00FF, ea);
		rd(ea, 1'b0, 8'h00);
		op2(fse_pkg::CMD_PROGRAM, dat, 1'b1);
		wait_ready();
		rd(ea, 1'b1, sbyte(1'b1, 1'b0, 1'b0));
		wr(16'h00FF, ea);
		rd(ea, 1'b0, 8'h00);
		@(posedge sys_clk);
		cpu_rewrite_mode_0 <= 1'b0;
		wr(16'h0070, ea);
		rd(ea, 1'b0, 8'h00);
		wrap_up();
	end

	initial begin
		repeat (100000) @(posedge sys_clk);
		num_errors++;
		$display("Error at %0t: run limit reached", $time);
		wrap_up();
	end
endmodule : tb
